//--- verilog/msd_pkg.sv
// Purpose: Shared constants for the switch input analog select block
// Assumes: 24-bit serial frames, command code in the top byte
// Notes: Inputs 0..13 are ground-switch, 14..21 the programmable group
package msd_pkg;
	localparam int NUM_INPUTS = 22;
	localparam int NUM_GROUND = 14;
	localparam int NUM_PROG = 8;
	localparam int FRAME_BITS = 24;
	localparam int CMD_LSB = 16;
	localparam int BANK_BIT = 15;
	localparam int ANA_MODE_LSB = 5;
	localparam logic [4:0] FRAME_COUNT = 5'h18;
	localparam logic [4:0] ANA_LIMIT = 5'h16;
	localparam logic [7:0] CMD_SETTINGS = 8'h01;
	localparam logic [7:0] CMD_METALLIC = 8'h02;
	localparam logic [7:0] CMD_WETTING = 8'h03;
	localparam logic [7:0] CMD_TRISTATE = 8'h04;
	localparam logic [7:0] CMD_ANALOG = 8'h05;
	localparam logic [7:0] CMD_SLEEP = 8'h0c;
	localparam logic [1:0] ANA_HIGHZ = 2'h0;
	localparam logic [1:0] ANA_LOW = 2'h1;
	localparam logic [1:0] ANA_HIGH = 2'h2;
	localparam logic [21:0] RST_TRISTATE = 22'h3f_ffff;
	localparam logic [21:0] RST_METALLIC = 22'h3f_ffff;
	localparam logic [21:0] RST_WETTING = 22'h3f_ffff;
	localparam logic [7:0] RST_SETTINGS = 8'hff;
	localparam logic [4:0] RST_ANA_SEL = 5'h00;
	typedef enum logic {MODE_NORMAL, MODE_SLEEP} msd_mode_t;
endpackage

//--- verilog/msd_frame_if.sv
// Purpose: Frame carrier between serial engine and control core
// Assumes: One clock domain, i_clock
// Notes: Pulses last one clock
`timescale 1ns/1ps
`default_nettype none
interface msd_frame_if;
	logic cs_fall;
	logic frame_done;
	logic [23:0] rx_word;
	logic [23:0] tx_word;
	logic so;
	logic so_oe;
	modport engine(output cs_fall, frame_done, rx_word, so, so_oe,
		input tx_word);
	modport core(input cs_fall, frame_done, rx_word, so, so_oe,
		output tx_word);
endinterface
`default_nettype wire

//--- verilog/msd_spi_engine.sv
// Purpose: Serial slave shifter, sampled on the system clock
// Assumes: Link clock idles low, data sampled on its rising edge
// Notes: Frames of other than 24 link clocks end without frame_done
`timescale 1ns/1ps
`default_nettype none
module msd_spi_engine
	import msd_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_reset,
	// Serial pins
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_si,
	// Frame carrier
	msd_frame_if.engine frame
);
	logic [2:0] sclk_reg;
	logic [2:0] cs_reg;
	logic [1:0] si_reg;
	logic [23:0] shift_reg;
	logic [23:0] rx_reg;
	logic [4:0] count_reg;
	logic so_reg;
	logic so_oe_reg;
	logic done_reg;
	logic fall_reg;
	wire sclk_rise = sclk_reg[1] & ~sclk_reg[2];
	wire sclk_fall = ~sclk_reg[1] & sclk_reg[2];
	wire cs_fall = ~cs_reg[1] & cs_reg[2];
	wire cs_rise = cs_reg[1] & ~cs_reg[2];
	wire active = ~cs_reg[1];

	// Stage 0 of each synchroniser feeds only stage 1
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			sclk_reg <= 3'h0;
			cs_reg <= 3'h7;
			si_reg <= 2'h0;
		end else begin
			sclk_reg <= {sclk_reg[1:0], i_sclk};
			cs_reg <= {cs_reg[1:0], i_cs_n};
			si_reg <= {si_reg[0], i_si};
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			shift_reg <= 24'h00_0000;
			rx_reg <= 24'h00_0000;
			count_reg <= 5'h00;
			so_reg <= 1'b0;
			so_oe_reg <= 1'b0;
		end else if (cs_fall) begin
			shift_reg <= frame.tx_word;
			count_reg <= 5'h00;
			so_reg <= frame.tx_word[23];
			so_oe_reg <= 1'b1;
		end else if (cs_rise) begin
			so_oe_reg <= 1'b0;
		end else if (active && sclk_rise) begin
			rx_reg <= {rx_reg[22:0], si_reg[1]};
			count_reg <= (count_reg == 5'h1f) ? count_reg : count_reg + 5'h01;
		end else if (active && sclk_fall) begin
			shift_reg <= {shift_reg[22:0], 1'b0};
			so_reg <= shift_reg[22];
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			done_reg <= 1'b0;
			fall_reg <= 1'b0;
		end else begin
			done_reg <= cs_rise && (count_reg == FRAME_COUNT);
			fall_reg <= cs_fall;
		end
	end

	assign frame.cs_fall = fall_reg;
	assign frame.frame_done = done_reg;
	assign frame.rx_word = rx_reg;
	assign frame.so = so_reg;
	assign frame.so_oe = so_oe_reg;
endmodule
`default_nettype wire

//--- verilog/msd_switch_core.sv
// Purpose: Analog select, input drive programming, status and wake
// Assumes: Pins are asynchronous to i_clock and are synchronised here
// Notes: Per-input commands use bit 15 to pick ground or programmable bank
`timescale 1ns/1ps
`default_nettype none
module msd_switch_core
	import msd_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_reset,
	// Serial pins
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_si,
	output logic o_so,
	output logic o_so_oe,
	// Supply and switch comparators
	input wire logic i_logic_supply_ok,
	input wire logic [21:0] i_switch_level,
	// Input drive controls
	output logic [21:0] o_source_enable,
	output logic [7:0] o_sink_enable,
	output logic [21:0] o_high_current,
	output logic [21:0] o_wetting_timer_enable,
	// Analog select and mode
	output logic [4:0] o_analog_select_output,
	output logic o_sleep,
	output logic o_so_invalid
);
	msd_frame_if frame();

	msd_spi_engine u_engine (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_sclk(i_sclk),
		.i_cs_n(i_cs_n),
		.i_si(i_si),
		.frame(frame.engine)
	);

	function automatic logic [21:0] apply_bank(input logic [21:0] old,
		input logic [23:0] word);
		logic [21:0] res;
		res = old;
		if (word[BANK_BIT])
			res[21:14] = word[7:0];
		else
			res[13:0] = word[13:0];
		return res;
	endfunction

	logic [21:0] level_s1_reg;
	logic [21:0] level_reg;
	logic [1:0] supply_reg;
	logic [21:0] tristate_reg;
	logic [21:0] metallic_reg;
	logic [21:0] wetting_reg;
	logic [7:0] settings_reg;
	logic [4:0] ana_sel_reg;
	logic [1:0] ana_mode_reg;
	msd_mode_t mode_reg;
	msd_mode_t mode_next;
	logic invalid_reg;
	logic [23:0] tx_word_reg;
	logic [21:0] source_reg;
	logic [7:0] sink_reg;
	logic [21:0] high_reg;

	wire [7:0] cmd = frame.rx_word[23:CMD_LSB];
	wire normal = (mode_reg == MODE_NORMAL);
	wire take = frame.frame_done && normal;
	wire take_ana = take && (cmd == CMD_ANALOG) &&
		(frame.rx_word[4:0] < ANA_LIMIT);
	wire wake = frame.cs_fall && !normal && supply_reg[1];
	wire [21:0] tristate_next = (take && cmd == CMD_TRISTATE) ?
		apply_bank(tristate_reg, frame.rx_word) : tristate_reg;
	wire [21:0] metallic_next = (take && cmd == CMD_METALLIC) ?
		apply_bank(metallic_reg, frame.rx_word) : metallic_reg;
	wire [21:0] wetting_next = (take && cmd == CMD_WETTING) ?
		apply_bank(wetting_reg, frame.rx_word) : wetting_reg;
	wire [7:0] settings_next = (take && cmd == CMD_SETTINGS) ?
		frame.rx_word[7:0] : settings_reg;
	wire [21:0] status_w;
	wire [21:0] source_w;
	wire [7:0] sink_w;
	wire [21:0] high_w;

	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			MODE_NORMAL: begin
				if (take && cmd == CMD_SLEEP)
					mode_next = MODE_SLEEP;
			end
			MODE_SLEEP: begin
				if (wake)
					mode_next = MODE_NORMAL;
			end
			default: mode_next = MODE_NORMAL;
		endcase
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_input
			wire is_ana = (ana_sel_reg == 5'(gi));
			wire closed;
			wire drive;
			if (gi < NUM_GROUND) begin : g_ground
				assign closed = ~level_reg[gi];
				assign drive = ~tristate_reg[gi];
			end else begin : g_prog
				wire to_batt = settings_reg[gi - NUM_GROUND];
				assign closed = to_batt ? level_reg[gi] : ~level_reg[gi];
				assign drive = ~tristate_reg[gi] & ~to_batt;
				// Analog use never sinks, so the pullup reading stays clean
				assign sink_w[gi - NUM_GROUND] = normal & ~is_ana &
					~tristate_reg[gi] & to_batt;
			end
			assign status_w[gi] = closed & ~is_ana;
			assign source_w[gi] = normal & (is_ana ?
				(ana_mode_reg != ANA_HIGHZ) : drive);
			assign high_w[gi] = is_ana ? (ana_mode_reg == ANA_HIGH) :
				metallic_reg[gi];
		end
	endgenerate

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			level_s1_reg <= 22'h00_0000;
			level_reg <= 22'h00_0000;
			supply_reg <= 2'h0;
		end else begin
			level_s1_reg <= i_switch_level;
			level_reg <= level_s1_reg;
			supply_reg <= {supply_reg[0], i_logic_supply_ok};
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			tristate_reg <= RST_TRISTATE;
			metallic_reg <= RST_METALLIC;
			wetting_reg <= RST_WETTING;
			settings_reg <= RST_SETTINGS;
			mode_reg <= MODE_NORMAL;
		end else begin
			tristate_reg <= tristate_next;
			metallic_reg <= metallic_next;
			wetting_reg <= wetting_next;
			settings_reg <= settings_next;
			mode_reg <= mode_next;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			ana_sel_reg <= RST_ANA_SEL;
			ana_mode_reg <= ANA_HIGHZ;
		end else if (take_ana) begin
			ana_sel_reg <= frame.rx_word[4:0];
			ana_mode_reg <= frame.rx_word[ANA_MODE_LSB +: 2];
		end
	end

	// Asleep, the shifter is loaded with zeros, so a waking frame is blank
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			invalid_reg <= 1'b0;
			tx_word_reg <= 24'h00_0000;
		end else begin
			invalid_reg <= wake | (invalid_reg & ~frame.frame_done);
			tx_word_reg <= normal ? {2'h0, status_w} : 24'h00_0000;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			source_reg <= 22'h00_0000;
			sink_reg <= 8'h00;
			high_reg <= 22'h00_0000;
		end else begin
			source_reg <= source_w;
			sink_reg <= sink_w;
			high_reg <= high_w & source_w;
		end
	end

	assign frame.tx_word = tx_word_reg;
	assign o_so = frame.so;
	assign o_so_oe = frame.so_oe;
	assign o_source_enable = source_reg;
	assign o_sink_enable = sink_reg;
	assign o_high_current = high_reg;
	assign o_wetting_timer_enable = wetting_reg;
	assign o_analog_select_output = ana_sel_reg;
	assign o_sleep = (mode_reg == MODE_SLEEP);
	assign o_so_invalid = invalid_reg;

	property p_sel_range;
		@(posedge i_clock) disable iff (i_reset)
		ana_sel_reg < ANA_LIMIT;
	endproperty
	a_sel_range: assert property (p_sel_range) else $error("select out of range");
	property p_sel_only_frame;
		@(posedge i_clock) disable iff (i_reset)
		$changed(ana_sel_reg) |-> $past(frame.frame_done) &&
			$past(cmd) == CMD_ANALOG && $past(normal);
	endproperty
	a_sel_only_frame: assert property (p_sel_only_frame) else $error("select moved");
	property p_sel_applied;
		@(posedge i_clock) disable iff (i_reset)
		take_ana |=> ana_sel_reg == $past(frame.rx_word[4:0]);
	endproperty
	a_sel_applied: assert property (p_sel_applied) else $error("select lost");
	property p_ana_status;
		@(posedge i_clock) disable iff (i_reset)
		normal |=> tx_word_reg[$past(ana_sel_reg)] == 1'b0;
	endproperty
	a_ana_status: assert property (p_ana_status) else $error("analog bit set");
	property p_reset_float;
		@(posedge i_clock) i_reset |=>
			o_source_enable == 22'h00_0000 && o_sink_enable == 8'h00;
	endproperty
	a_reset_float: assert property (p_reset_float) else $error("drive in reset");
	property p_prog_sink;
		@(posedge i_clock) disable iff (i_reset)
		normal && !tristate_reg[14] && settings_reg[0] && ana_sel_reg != 5'h0e
			|=> o_sink_enable[0] && !o_source_enable[14];
	endproperty
	a_prog_sink: assert property (p_prog_sink) else $error("no sink");
	property p_prog_source;
		@(posedge i_clock) disable iff (i_reset)
		normal && !tristate_reg[21] && !settings_reg[7] && ana_sel_reg != 5'h15
			|=> o_source_enable[21] && !o_sink_enable[7];
	endproperty
	a_prog_source: assert property (p_prog_source) else $error("no source");
	property p_ground_drive;
		@(posedge i_clock) disable iff (i_reset)
		normal && ana_sel_reg != 5'h01 |=>
			o_source_enable[1] == !$past(tristate_reg[1]);
	endproperty
	a_ground_drive: assert property (p_ground_drive) else $error("bad pullup");
	property p_open_load;
		@(posedge i_clock) disable iff (i_reset)
		normal && tristate_reg[1] && !level_reg[1] && ana_sel_reg != 5'h01
			|=> tx_word_reg[1];
	endproperty
	a_open_load: assert property (p_open_load) else $error("low not 1");
	property p_wetting;
		@(posedge i_clock) disable iff (i_reset)
		take && cmd == CMD_WETTING && frame.rx_word[BANK_BIT]
			|=> o_wetting_timer_enable[21:14] == $past(frame.rx_word[7:0]);
	endproperty
	a_wetting: assert property (p_wetting) else $error("wetting missed");
	property p_no_wake;
		@(posedge i_clock) disable iff (i_reset)
		!normal && frame.cs_fall && !supply_reg[1] |=> o_sleep;
	endproperty
	a_no_wake: assert property (p_no_wake) else $error("woke unpowered");
	property p_wake;
		@(posedge i_clock) disable iff (i_reset)
		!normal && frame.cs_fall && supply_reg[1] |=> !o_sleep && o_so_invalid;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");
	c_analog: cover property (@(posedge i_clock) take_ana);
	c_sleep: cover property (@(posedge i_clock) take && cmd == CMD_SLEEP);
	c_wake: cover property (@(posedge i_clock) wake);
	c_sink: cover property (@(posedge i_clock) o_sink_enable != 8'h00);
endmodule
`default_nettype wire

//--- sim/msd_spi_master.sv
// Purpose: Serial master model for the switch core link
// Assumes: Mode 0, MSB first, caller starts just after a system clock edge
// Notes: Link clock stands low between frames; half is raised for slow runs
`timescale 1ns/1ps
`default_nettype none
module msd_spi_master (
	// Link pins
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_si,
	input wire logic i_so
);
	int half = 200;
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b0;
	end
	task automatic xfer(input logic [23:0] w, output logic [23:0] rx);
		rx = 24'h00_0000;
		o_cs_n = 1'b0;
		#100;
		for (int b = 23; b >= 0; b--) begin
			o_si = w[b];
			#(half);
			o_sclk = 1'b1;
			rx[b] = i_so;
			#(half);
			o_sclk = 1'b0;
		end
		#200;
		o_cs_n = 1'b1;
		// Deselected data line must not look like a held bit
		o_si = ~o_si;
		#700;
	endtask
endmodule
`default_nettype wire

//--- sim/msd_switch_core_tb.sv
// Purpose: Self-checking bench for the switch core
// Assumes: 20 MHz system clock, link clock of 400 ns per bit
// Notes: Expected values are queued and compared by a watcher process
`timescale 1ns/1ps
`default_nettype none
module msd_switch_core_tb
	import msd_pkg::*;
;
	typedef struct {int sel; logic [23:0] v;} msd_note_t;
	logic i_clock, i_reset, sclk, cs_n, si, so, so_oe, supply_ok;
	logic [21:0] level, src, hi, wet;
	logic [7:0] snk;
	logic [4:0] asel;
	logic slp, inv;
	logic [23:0] rx;
	msd_note_t q[$];
	string names[9] = '{"so", "sel", "src", "snk", "hi", "wet", "slp", "inv",
		"oe"};
	int fails = 0;
	int n_compared = 0;
	int cycles = 0;
	int seed = 32'h2ecb;

	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end

	msd_switch_core u_dut (
		.i_clock(i_clock), .i_reset(i_reset), .i_sclk(sclk), .i_cs_n(cs_n),
		.i_si(si), .o_so(so), .o_so_oe(so_oe),
		.i_logic_supply_ok(supply_ok), .i_switch_level(level),
		.o_source_enable(src), .o_sink_enable(snk), .o_high_current(hi),
		.o_wetting_timer_enable(wet), .o_analog_select_output(asel),
		.o_sleep(slp), .o_so_invalid(inv)
	);
	msd_spi_master u_master (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si),
		.i_so(so));

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [23:0] s,
		input logic [23:0] e);
		n_compared++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic note_v(input int sel, input logic [23:0] v);
		q.push_back('{sel, v});
	endtask

	task automatic send(input logic [7:0] cmd, input logic [15:0] d);
		@(posedge i_clock);
		#1;
		u_master.xfer({cmd, d}, rx);
	endtask

	task automatic do_reset();
		@(posedge i_clock);
		#1 i_reset = 1'b1;
		repeat (20) @(posedge i_clock);
		#1 i_reset = 1'b0;
		repeat (3) @(posedge i_clock);
		note_v(2, 24'h00_0000); note_v(3, 24'h00_0000);
		note_v(4, 24'h00_0000); note_v(5, 24'h3f_ffff);
		note_v(1, 24'h00_0000); note_v(6, 24'h00_0000);
		note_v(7, 24'h00_0000);
		note_v(8, 24'h00_0000);
		$display("test reset done");
	endtask

	function automatic logic [23:0] seen(input int sel);
		case (sel)
		0: return rx;
		1: return {19'h0_0000, asel};
		2: return {2'h0, src};
		3: return {16'h0000, snk};
		4: return {2'h0, hi};
		5: return {2'h0, wet};
		6: return {23'h00_0000, slp};
		7: return {23'h00_0000, inv};
		default: return {23'h00_0000, so_oe};
		endcase
	endfunction

	// Watcher: compares each queued note against the live outputs
	initial begin
		msd_note_t n;
		forever begin
			@(negedge i_clock);
			while (q.size() > 0) begin
				n = q.pop_front();
				check(names[n.sel], seen(n.sel), n.v);
			end
		end
	end

	// Ceiling is about three and a half times the expected run length
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			wrap_up();
		end
	end

	initial begin
		logic [21:0] lvl;
		logic [4:0] k;
		logic [23:0] st;
		i_reset = 1'b1;
		level = 22'h00_0000;
		supply_ok = 1'b1;
		do_reset();
		for (int t = 0; t < 4; t++) begin
			lvl = 22'($random(seed));
			k = 5'({$random(seed)} % 22);
			@(posedge i_clock);
			#1 level = lvl;
			send(CMD_ANALOG, {11'h000, k});
			note_v(1, 24'(k));
			send(8'h00, 16'h0000);
			st = {2'h0, lvl[21:14], ~lvl[13:0]};
			st[k] = 1'b0;
			note_v(0, st);
			note_v(1, 24'(k));
		end
		$display("test status done");
		for (int m = 0; m < 3; m++) begin
			fork
				send(CMD_ANALOG, {9'h000, 2'(m), 5'h03});
				begin
					@(negedge cs_n);
					#9700 note_v(1, 24'(k));
					note_v(8, 24'h00_0001);
				end
			join
			k = 5'h03;
			note_v(2, (m > 0) ? 24'h00_0008 : 24'h00_0000);
			note_v(4, (m == 2) ? 24'h00_0008 : 24'h00_0000);
		end
		send(CMD_ANALOG, {11'h000, ANA_LIMIT});
		note_v(1, 24'h00_0003);
		send(CMD_ANALOG, 16'h0000);
		$display("test analog done");
		send(CMD_TRISTATE, 16'h0001);
		note_v(2, 24'h00_3ffe); note_v(4, 24'h00_3ffe);
		send(CMD_METALLIC, 16'h0000);
		note_v(4, 24'h00_0000); note_v(2, 24'h00_3ffe);
		send(CMD_METALLIC, 16'h3fff);
		note_v(4, 24'h00_3ffe);
		send(CMD_TRISTATE, 16'h3fff);
		note_v(2, 24'h00_0000);
		send(CMD_TRISTATE, 16'h8000);
		note_v(3, 24'h00_00ff); note_v(2, 24'h00_0000);
		send(CMD_SETTINGS, 16'h800f);
		note_v(3, 24'h00_000f); note_v(2, 24'h3c_0000);
		note_v(4, 24'h3c_0000);
		send(CMD_METALLIC, 16'h8000);
		note_v(4, 24'h00_0000);
		send(CMD_SETTINGS, 16'h80ff);
		note_v(3, 24'h00_00ff); note_v(2, 24'h00_0000);
		send(CMD_WETTING, 16'h0000);
		note_v(5, 24'h3f_c000);
		send(CMD_WETTING, 16'h8000);
		note_v(5, 24'h00_0000);
		$display("test drive done");
		send(CMD_SLEEP, 16'h0000);
		note_v(6, 24'h00_0001);
		@(posedge i_clock);
		#1 supply_ok = 1'b0;
		send(8'h00, 16'h0000);
		note_v(6, 24'h00_0001);
		@(posedge i_clock);
		#1 supply_ok = 1'b1;
		fork
			send(8'h00, 16'h0000);
			begin
				@(negedge cs_n);
				#600 note_v(7, 24'h00_0001);
			end
		join
		note_v(0, 24'h00_0000); note_v(6, 24'h00_0000);
		note_v(1, 24'h00_0000);
		note_v(7, 24'h00_0000);
		$display("test wake done");
		do_reset();
		repeat (2) @(negedge i_clock);
		wrap_up();
	end
endmodule
`default_nettype wire
